// ### core/port3_pkg.sv
// Register map, field layout and reset values of the one-pin port
package port3_pkg;
  // Printed offsets, kept as word indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE_A_THRESHOLD = 8'hac;
  localparam logic [7:0] IDX_MODE_B_SLEW      = 8'had;
  localparam logic [7:0] IDX_PIN_DATA         = 8'hb0;
  localparam logic [7:0] IDX_PORT_CONTROL     = 8'hc0;
  localparam logic [7:0] IDX_PORT_STATUS      = 8'hc1;

  // Field positions
  localparam int BIT_PIN        = 0;
  localparam int BIT_PAGE       = 0;
  localparam int BIT_INT_OSC    = 1;
  localparam int BIT_ST_LEVEL   = 0;
  localparam int BIT_ST_MODE_LO = 1;
  localparam int BIT_ST_MODE_HI = 2;
  localparam int BIT_ST_GPIO    = 3;

  // Reset values
  localparam logic MODE_A_RST    = 1'b1;
  localparam logic MODE_B_RST    = 1'b0;
  localparam logic THRESHOLD_RST = 1'b0;
  localparam logic SLEW_RST      = 1'b0;
  localparam logic LATCH_RST     = 1'b1;
  localparam logic PAGE_RST      = 1'b0;
  localparam logic INT_OSC_RST   = 1'b1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Pin mode, first mode bit is the high bit of the code
  typedef enum logic [1:0] {
    MODE_QUASI      = 2'b00,
    MODE_PUSH_PULL  = 2'b01,
    MODE_INPUT      = 2'b10,
    MODE_OPEN_DRAIN = 2'b11
  } pin_mode_t;
endpackage : port3_pkg

// ### core/port3_single_pin_control.sv
// One-pin general purpose port with AXI4-Lite register access
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module port3_single_pin_control #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // Pin side
  input  wire logic              pin_in,
  output logic                   pin_out,
  output logic                   pin_oe,
  output logic                   pin_weak_pullup,
  output logic                   pin_schmitt_en,
  output logic                   pin_fast_slew,
  output logic                   osc_in_select
);

  // The index compare needs eight address bits above the byte lane
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W must be 10 to 32");
  end

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] awaddr;
    logic              wbit0;
    logic              wbit1;
    logic              wen0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic              mode_a;
    logic              mode_b;
    logic              schmitt;
    logic              slew;
    logic              latch;
    logic              page;
    logic              int_osc;
    logic              pin_sample;
    logic              pin_out;
    logic              pin_oe;
    logic              weak_pullup;
    logic              schmitt_en;
    logic              fast_slew;
    logic              osc_sel;
  } state_t;

  state_t s;
  state_t next_s;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a[ADDR_W-1:2] == {{(ADDR_W-10){1'b0}}, idx});
  endfunction : hit

  logic                 commit;
  logic                 rd_take;
  logic [31:0]          rd_word;
  logic                 rd_ok;
  port3_pkg::pin_mode_t mode;

  assign commit  = s.aw_held && s.w_held && !s.bvalid;
  assign rd_take = s_axi_arvalid && s.arready;
  assign mode    = port3_pkg::pin_mode_t'({s.mode_a, s.mode_b});

  // Read mux; every unimplemented bit reads zero
  always_comb begin
    rd_word = 32'h0;
    rd_ok   = 1'b1;
    if (hit(s_axi_araddr, port3_pkg::IDX_MODE_A_THRESHOLD)) begin
      rd_word[port3_pkg::BIT_PIN] = s.page ? s.schmitt : s.mode_a;
    end else if (hit(s_axi_araddr, port3_pkg::IDX_MODE_B_SLEW)) begin
      rd_word[port3_pkg::BIT_PIN] = s.page ? s.slew : s.mode_b;
    end else if (hit(s_axi_araddr, port3_pkg::IDX_PIN_DATA)) begin
      rd_word[port3_pkg::BIT_PIN] = s.int_osc && s.pin_sample;
    end else if (hit(s_axi_araddr, port3_pkg::IDX_PORT_CONTROL)) begin
      rd_word[port3_pkg::BIT_PAGE]    = s.page;
      rd_word[port3_pkg::BIT_INT_OSC] = s.int_osc;
    end else if (hit(s_axi_araddr, port3_pkg::IDX_PORT_STATUS)) begin
      rd_word[port3_pkg::BIT_ST_LEVEL]   = s.pin_sample;
      rd_word[port3_pkg::BIT_ST_MODE_LO] = s.mode_b;
      rd_word[port3_pkg::BIT_ST_MODE_HI] = s.mode_a;
      rd_word[port3_pkg::BIT_ST_GPIO]    = s.int_osc;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_comb begin
    next_s            = s;
    next_s.pin_sample = pin_in;

    // Write channel: address and data are captured separately, in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wbit0  = s_axi_wdata[0];
      next_s.wbit1  = s_axi_wdata[1];
      next_s.wen0   = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (commit) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = port3_pkg::RESP_OKAY;
      if (hit(s.awaddr, port3_pkg::IDX_MODE_A_THRESHOLD)) begin
        if (s.wen0 && s.page) next_s.schmitt = s.wbit0;
        if (s.wen0 && !s.page) next_s.mode_a = s.wbit0;
      end else if (hit(s.awaddr, port3_pkg::IDX_MODE_B_SLEW)) begin
        if (s.wen0 && s.page) next_s.slew = s.wbit0;
        if (s.wen0 && !s.page) next_s.mode_b = s.wbit0;
      end else if (hit(s.awaddr, port3_pkg::IDX_PIN_DATA)) begin
        // Latch is frozen while the pin serves the oscillator
        if (s.wen0 && s.int_osc) next_s.latch = s.wbit0;
      end else if (hit(s.awaddr, port3_pkg::IDX_PORT_CONTROL)) begin
        if (s.wen0) begin
          next_s.page    = s.wbit0;
          next_s.int_osc = s.wbit1;
        end
      end else if (!hit(s.awaddr, port3_pkg::IDX_PORT_STATUS)) begin
        next_s.bresp = port3_pkg::RESP_DECERR;
      end
    end
    next_s.awready = !next_s.aw_held;
    next_s.wready  = !next_s.w_held;

    // Read channel: one read outstanding, answered the cycle after it is taken
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_take) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_word;
      next_s.rresp  = rd_ok ? port3_pkg::RESP_OKAY : port3_pkg::RESP_DECERR;
    end
    next_s.arready = !next_s.rvalid;

    // Pin driver follows the current configuration one cycle later
    next_s.pin_out     = 1'b0;
    next_s.pin_oe      = 1'b0;
    next_s.weak_pullup = 1'b0;
    unique case (mode)
      port3_pkg::MODE_QUASI: begin
        next_s.pin_oe      = !s.latch;
        next_s.weak_pullup = s.latch;
      end
      port3_pkg::MODE_PUSH_PULL: begin
        next_s.pin_oe  = 1'b1;
        next_s.pin_out = s.latch;
      end
      port3_pkg::MODE_INPUT: begin
        next_s.pin_oe = 1'b0;
      end
      port3_pkg::MODE_OPEN_DRAIN: begin
        next_s.pin_oe = !s.latch;
      end
    endcase
    if (!s.int_osc) begin
      next_s.pin_oe      = 1'b0;
      next_s.weak_pullup = 1'b0;
    end
    next_s.osc_sel    = !s.int_osc;
    next_s.schmitt_en = s.schmitt;
    next_s.fast_slew  = s.slew;

    if (!aresetn) begin
      next_s         = '0;
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
      next_s.arready = 1'b1;
      next_s.mode_a  = port3_pkg::MODE_A_RST;
      next_s.mode_b  = port3_pkg::MODE_B_RST;
      next_s.schmitt = port3_pkg::THRESHOLD_RST;
      next_s.slew    = port3_pkg::SLEW_RST;
      next_s.latch   = port3_pkg::LATCH_RST;
      next_s.page    = port3_pkg::PAGE_RST;
      next_s.int_osc = port3_pkg::INT_OSC_RST;
    end
  end

  always_ff @(posedge aclk) begin
    s <= next_s;
  end

  assign s_axi_awready   = s.awready;
  assign s_axi_wready    = s.wready;
  assign s_axi_bvalid    = s.bvalid;
  assign s_axi_bresp     = s.bresp;
  assign s_axi_arready   = s.arready;
  assign s_axi_rvalid    = s.rvalid;
  assign s_axi_rdata     = s.rdata;
  assign s_axi_rresp     = s.rresp;
  assign pin_out         = s.pin_out;
  assign pin_oe          = s.pin_oe;
  assign pin_weak_pullup = s.weak_pullup;
  assign pin_schmitt_en  = s.schmitt_en;
  assign pin_fast_slew   = s.fast_slew;
  assign osc_in_select   = s.osc_sel;

  AST_INPUT_ONLY_FLOATS: assert property (@(posedge aclk) disable iff (!aresetn)
    s.mode_a && !s.mode_b |=> !pin_oe && !pin_weak_pullup)
    else $error("input-only mode drives the pin");

  AST_PUSH_PULL_DRIVES: assert property (@(posedge aclk) disable iff (!aresetn)
    s.int_osc && !s.mode_a && s.mode_b |=> pin_oe && (pin_out == $past(s.latch)))
    else $error("push-pull mode does not drive the latch value");

  AST_OPEN_DRAIN_SINKS: assert property (@(posedge aclk) disable iff (!aresetn)
    s.int_osc && s.mode_a && s.mode_b |=> !pin_out && (pin_oe == !$past(s.latch)))
    else $error("open-drain mode drives wrongly");

  AST_RESET_MODE_A: assert property (@(posedge aclk)
    !aresetn |=> s.mode_a && !s.mode_b ##1 !pin_oe)
    else $error("pin not input-only after reset");

  AST_RESET_TTL: assert property (@(posedge aclk)
    !aresetn |=> !s.schmitt ##1 !pin_schmitt_en)
    else $error("threshold not TTL after reset");

  AST_SCHMITT_FOLLOWS: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && s.page && s.wen0 && hit(s.awaddr, port3_pkg::IDX_MODE_A_THRESHOLD)
    |=> ##1 pin_schmitt_en == $past(s.wbit0, 2))
    else $error("Schmitt select does not follow the write");

  AST_SLEW_FOLLOWS: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && s.page && s.wen0 && hit(s.awaddr, port3_pkg::IDX_MODE_B_SLEW)
    |=> ##1 pin_fast_slew == $past(s.wbit0, 2))
    else $error("slew select does not follow the write");

  AST_PAGE0_KEEPS_THRESHOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && !s.page && hit(s.awaddr, port3_pkg::IDX_MODE_A_THRESHOLD)
    |=> $stable(s.schmitt))
    else $error("page 0 write changed the threshold bit");

  AST_UPPER_BITS_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_take && !hit(s_axi_araddr, port3_pkg::IDX_PORT_CONTROL)
    && !hit(s_axi_araddr, port3_pkg::IDX_PORT_STATUS) |=> s_axi_rdata[31:1] == 31'h0)
    else $error("reserved bits read nonzero");

  AST_OSC_READS_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_take && !s.int_osc && hit(s_axi_araddr, port3_pkg::IDX_PIN_DATA)
    |=> !s_axi_rdata[0])
    else $error("pin data read nonzero in oscillator mode");

  // A clock-source write may hand the pin back, so it is left out here
  AST_OSC_LATCH_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && !s.int_osc && !hit(s.awaddr, port3_pkg::IDX_PORT_CONTROL)
    |=> $stable(s.latch) ##1 !pin_oe && osc_in_select)
    else $error("oscillator mode let the pin or latch change");

  AST_READ_SAMPLED_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_take && s.int_osc && hit(s_axi_araddr, port3_pkg::IDX_PIN_DATA)
    |=> s_axi_rdata[0] == $past(s.pin_sample) ##1 !s_axi_rvalid || $stable(s_axi_rdata))
    else $error("pin data read is not the sampled level");

endmodule : port3_single_pin_control

// ### dv/pin_far_side.sv
// Far-side model of the single port pin
`timescale 1ns/10ps
module pin_far_side (
  // Pin from the port
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic pin_weak_pullup,
  // Outside driver used once the port lets go with its pull-up off
  input  wire logic ext_level,
  output logic      pin_in
);
  // A released pin without pull-up follows the outside driver, never a held value
  assign pin_in = pin_oe ? pin_out : (pin_weak_pullup ? 1'b1 : ext_level);
endmodule : pin_far_side

// ### dv/port3_single_pin_control_tb_top.sv
// Self-checking bench for the one-pin port
`timescale 1ns/10ps
module port3_single_pin_control_tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, rd, seed = 32'hb693;
  logic [1:0]  bresp, rresp, rsp;
  logic        awready, wready, bvalid, arready, rvalid, pin_in, pin_out, pin_oe;
  logic        pin_pu, pin_st, pin_fs, osc_sel, ext = 1'b0, lat, lv;
  logic [2:0]  e;
  int          error_cnt = 0, cmp_count = 0, cyc = 0;

  always #20 aclk = ~aclk;

  port3_single_pin_control #(.ADDR_W(12)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_weak_pullup(pin_pu), .pin_schmitt_en(pin_st), .pin_fast_slew(pin_fs),
    .osc_in_select(osc_sel)
  );

  pin_far_side far (
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_weak_pullup(pin_pu),
    .ext_level(ext), .pin_in(pin_in)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // {oe, driven level, pull-up} for mode bits a, b and output latch l
  function automatic logic [2:0] pin_exp(input logic a, input logic b, input logic l);
    case ({a, b})
      2'b00: return {~l, 1'b0, l};
      2'b01: return {1'b1, l, 1'b0};
      2'b10: return 3'b000;
      default: return {~l, 1'b0, 1'b0};
    endcase
  endfunction : pin_exp

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask : chk

  // Ready is registered, so its level at the falling edge is what the next edge samples
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      rsp = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb);
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] idx, output logic [31:0] d);
    logic ha, hr;
    @(posedge aclk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end while (!hr);
    rready <= 1'b0;
  endtask : rdr

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    rdr(idx, rd);
    chk(what, exp, rd);
    chk("rresp", port3_pkg::RESP_OKAY, rsp);
  endtask : rchk

  // Called at a rising edge; holds reset for n edges, then checks the reset state
  task automatic reset_check(input int n);
    aresetn <= 1'b0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(negedge aclk);
    chk("reset pins", 5'h00, {pin_oe, pin_pu, pin_st, pin_fs, osc_sel});
    rchk(port3_pkg::IDX_MODE_A_THRESHOLD, 32'h1, "mode a");
    rchk(port3_pkg::IDX_MODE_B_SLEW, 32'h0, "mode b");
  endtask : reset_check

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // Whole run needs a few hundred cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    reset_check(10);
    wr(port3_pkg::IDX_PORT_CONTROL, 32'h3);
    chk("bresp", port3_pkg::RESP_OKAY, rsp);
    rchk(port3_pkg::IDX_PORT_CONTROL, 32'h3, "control");
    rchk(port3_pkg::IDX_MODE_A_THRESHOLD, 32'h0, "threshold");
    rchk(port3_pkg::IDX_MODE_B_SLEW, 32'h0, "slew");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(port3_pkg::IDX_MODE_A_THRESHOLD, {rnd() & 32'hfffffffe} | i[0]);
      wr(port3_pkg::IDX_MODE_B_SLEW, {rnd() & 32'hfffffffe} | i[1]);
      repeat (2) @(negedge aclk);
      chk("schmitt", i[0], pin_st);
      chk("fast slew", i[1], pin_fs);
      rchk(port3_pkg::IDX_MODE_A_THRESHOLD, i[0], "threshold rb");
      rchk(port3_pkg::IDX_MODE_B_SLEW, i[1], "slew rb");
    end
    $display("test threshold and slew done");
    wr(port3_pkg::IDX_PORT_CONTROL, 32'h2);
    for (int i = 0; i < 8; i++) begin
      lat = 1'(rnd());
      ext <= 1'(rnd());
      wr(port3_pkg::IDX_MODE_A_THRESHOLD, i[1]);
      wr(port3_pkg::IDX_MODE_B_SLEW, i[0]);
      wr(port3_pkg::IDX_PIN_DATA, {rnd() & 32'hfffffffe} | lat);
      repeat (2) @(negedge aclk);
      e = pin_exp(i[1], i[0], lat);
      lv = e[2] ? e[1] : (e[0] | ext);
      chk("pin drive", e, {pin_oe, pin_oe & pin_out, pin_pu});
      rchk(port3_pkg::IDX_PIN_DATA, {31'h0, lv}, "pin data");
      rchk(port3_pkg::IDX_PORT_STATUS, {28'h0, 1'b1, i[1], i[0], lv}, "status");
      rchk(port3_pkg::IDX_MODE_A_THRESHOLD, i[1], "mode a rb");
    end
    $display("test modes done");
    wr(port3_pkg::IDX_MODE_A_THRESHOLD, 32'h0);
    wr(port3_pkg::IDX_MODE_B_SLEW, 32'h1);
    wr(port3_pkg::IDX_PIN_DATA, 32'h1);
    wr(port3_pkg::IDX_PORT_CONTROL, 32'h0);
    repeat (2) @(negedge aclk);
    chk("osc select", 2'b10, {osc_sel, pin_oe});
    rchk(port3_pkg::IDX_PIN_DATA, 32'h0, "osc data");
    wr(port3_pkg::IDX_PIN_DATA, 32'h0);
    wr(port3_pkg::IDX_PORT_CONTROL, 32'h2);
    repeat (2) @(negedge aclk);
    chk("latch kept", 3'b011, {osc_sel, pin_oe, pin_out});
    $display("test oscillator input done");
    @(posedge aclk);
    reset_check(2);
    $display("test mid-run reset done");
    wr(8'h10, rnd());
    chk("bresp", port3_pkg::RESP_DECERR, rsp);
    rdr(8'h10, rd);
    chk("unmapped rresp", port3_pkg::RESP_DECERR, rsp);
    chk("unmapped rdata", 32'h0, rd);
    $display("test unmapped done");
    end_of_test();
  end
endmodule : port3_single_pin_control_tb_top
